//--- design/mdcs_top.sv
/*
 * Multi-device sync clock alignment: divide-by-four sync clock, master
 * pulse generation, slave comparison with offset, manual software and
 * hardware stalls, active register copies and the sync status flag.
 * Assumes the serial port presents buffered register values, a same-clock
 * read strobe for register two, and the commit strobe from a pin.
 */
`timescale 1ns/1ns
module mdcs_top (
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               clk_en,
    input  wire mdcs_pkg::mdcs_fr1_t function_reg_one_buf,
    input  wire mdcs_pkg::mdcs_fr2_t function_reg_two_buf,
    input  wire logic               io_update,
    input  wire logic               reg_two_read,
    input  wire logic               sync_in,
    output logic                    sync_out,
    output logic                    sync_clk,
    output mdcs_pkg::mdcs_fr1_t     function_reg_one,
    output mdcs_pkg::mdcs_fr2_t     function_reg_two
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Modulo-four add, shared by divider step and expected phase
    function automatic logic [1:0] cnt_add(input logic [1:0] a,
                                           input logic [1:0] b);
        cnt_add = a + b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    mdcs_pkg::mdcs_state_t st;
    mdcs_pkg::mdcs_state_t next_st;

    logic       commit;
    logic       sin_rise;
    logic       tap;
    logic       slave_act;
    logic       sw_stall;
    logic       hw_stall;
    logic       mismatch;
    logic       stall;
    logic [1:0] expect_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Whole block in one process so all state freezes together
    always_comb begin
        next_st = st;

        // Pin stages: first flop only feeds the second
        next_st.upd = {st.upd[1:0], io_update};
        next_st.sin = {st.sin[1], st.sin[0], sync_in};

        // Commit on rising edge of the synchronised strobe
        commit   = st.upd[1] & ~st.upd[2];
        // Idle-high input gives no edge while floating
        sin_rise = st.sin[1] & ~st.sin[2];

        // Delay line gives the offset taps
        next_st.dly = {st.dly[1:0], st.sin[1]};
        unique case (st.fr2.offset)
            2'h0: tap = st.sin[1];
            2'h1: tap = st.dly[0];
            2'h2: tap = st.dly[1];
            2'h3: tap = st.dly[2];
        endcase

        // Aligned slave sits at synchroniser latency plus wire delay plus
        // tap delay; the offset code stands for both delays
        expect_cnt = cnt_add(cnt_add(mdcs_pkg::SYNC_LAT, st.fr2.offset),
                             st.fr2.offset);

        // Automatic slave comparison
        slave_act = st.fr2.auto_en & ~st.fr2.master;
        mismatch  = slave_act & tap & (st.cnt != expect_cnt);

        // Software stall only on the commit that clears the bit
        sw_stall = commit & st.fr1.sw_sync & ~function_reg_one_buf.sw_sync;
        // Hardware stall on each synchronised rising edge
        hw_stall = st.fr1.hw_sync & sin_rise;

        stall = sw_stall | hw_stall | mismatch;

        // One held cycle moves the phase by a quarter period
        if (stall) begin
            next_st.cnt = st.cnt;
        end else begin
            next_st.cnt = cnt_add(st.cnt, mdcs_pkg::CNT_STEP);
        end
        next_st.sync_clk = next_st.cnt[1];

        // Buffer values act only on commit; status is not writable
        if (commit) begin
            next_st.fr1             = function_reg_one_buf;
            next_st.fr2.auto_en     = function_reg_two_buf.auto_en;
            next_st.fr2.master      = function_reg_two_buf.master;
            next_st.fr2.mask        = function_reg_two_buf.mask;
            next_st.fr2.offset      = function_reg_two_buf.offset;
            next_st.fr2.rsvd        = mdcs_pkg::RSVD_VAL;
        end

        // Read clears the flag, but a new miss in that cycle wins
        if (reg_two_read) begin
            next_st.fr2.status = 1'b0;
        end
        if (mismatch) begin
            next_st.fr2.status = 1'b1;
        end
        // Mask only hides the flag; comparison keeps stalling
        if (next_st.fr2.mask) begin
            next_st.fr2.status = 1'b0;
        end

        // Master pulse, one clock wide once per four
        next_st.sync_out = next_st.fr2.auto_en & next_st.fr2.master &
                           (next_st.cnt == mdcs_pkg::CNT_PULSE);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    // Clock enable low freezes everything, synchronisers included
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st.upd      <= mdcs_pkg::STB_IDLE;
            st.sin      <= mdcs_pkg::PIN_IDLE;
            st.dly      <= mdcs_pkg::DLY_RST;
            st.cnt      <= mdcs_pkg::CNT_RST;
            st.sync_clk <= mdcs_pkg::SCLK_RST;
            st.sync_out <= 1'b0;
            st.fr1      <= mdcs_pkg::FR1_RST;
            st.fr2      <= mdcs_pkg::FR2_RST;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from state flops

    assign sync_out         = st.sync_out;
    assign sync_clk         = st.sync_clk;
    assign function_reg_one = st.fr1;
    assign function_reg_two = st.fr2;

    ////////////////////////////////////////////////////////////////////////
    // Assertions, sampled on enabled edges except the freeze check

    // Pulse only in master counter zero with automatic mode on
    master_pulse_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        st.sync_out |-> (st.cnt == mdcs_pkg::CNT_PULSE) &&
                        st.fr2.auto_en && st.fr2.master)
        else $error("sync pulse outside master phase zero");

    // Undisturbed master repeats its pulse every fourth clock
    pulse_period_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        (st.sync_out && !commit && !st.fr1.hw_sync && !st.upd[1])
        |=> !st.sync_out [*3] ##1 (st.sync_out || $past(commit) ||
            $past(commit, 2) || $past(commit, 3)))
        else $error("master pulse period is not four clocks");

    // Without a stall the divider steps by one
    div_step_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        !stall |=> st.cnt == cnt_add($past(st.cnt), 2'h1))
        else $error("divider did not advance");

    // Any stall source holds the divider for one edge
    stall_hold_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        stall |=> st.cnt == $past(st.cnt))
        else $error("stall did not hold the divider");

    // Slave miss holds the divider exactly one cycle
    slave_stall_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        (slave_act && tap && st.cnt != expect_cnt)
        |=> st.cnt == $past(st.cnt))
        else $error("slave mismatch did not stall");

    // Slave with no delayed pulse never stalls on its own
    offset_tap_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        (slave_act && !tap && !sw_stall && !hw_stall)
        |=> st.cnt == cnt_add($past(st.cnt), 2'h1))
        else $error("slave stalled without a delayed pulse");

    // Commit clearing the software bit stalls once
    sw_stall_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        (commit && st.fr1.sw_sync && !function_reg_one_buf.sw_sync)
        |=> st.cnt == $past(st.cnt) && !st.fr1.sw_sync)
        else $error("software sync commit did not stall");

    // Any other commit leaves the divider running; a commit that
    // sets the software bit must not stall
    sw_keep_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        (commit && !(st.fr1.sw_sync && !function_reg_one_buf.sw_sync) &&
         !hw_stall && !mismatch)
        |=> st.cnt == cnt_add($past(st.cnt), 2'h1))
        else $error("commit stalled without clearing software bit");

    // Hardware mode edge stalls the divider
    hw_stall_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        (st.fr1.hw_sync && st.sin[1] && !st.sin[2])
        |=> st.cnt == $past(st.cnt))
        else $error("hardware sync edge did not stall");

    // Input edges are ignored while hardware mode is off
    hw_idle_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        (sin_rise && !st.fr1.hw_sync && !sw_stall && !mismatch)
        |=> st.cnt == cnt_add($past(st.cnt), 2'h1))
        else $error("sync input edge stalled outside hardware mode");

    // Masked flag stays low
    status_mask_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        st.fr2.mask |-> !st.fr2.status)
        else $error("masked status flag is high");

    // Unmasked miss raises the flag, also over a read
    status_set_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        (mismatch && !commit && !st.fr2.mask) |=> st.fr2.status)
        else $error("status flag not set by slave miss");

    // Read with no new miss clears the flag
    status_clear_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        (reg_two_read && !mismatch) |=> !st.fr2.status)
        else $error("status flag not cleared by read");

    // Only a slave miss can raise the flag
    status_source_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        $rose(st.fr2.status) |-> $past(mismatch))
        else $error("status flag rose without a miss");

    // Committed controls match the buffer one edge later
    commit_copy_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        commit |=> st.fr1 == $past(function_reg_one_buf) &&
                   st.fr2.offset == $past(function_reg_two_buf.offset) &&
                   st.fr2.rsvd == 2'h0)
        else $error("commit did not load active registers");

    // A strobe held high commits only once
    commit_once_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        commit |=> !commit)
        else $error("held commit strobe committed twice");

    // Without a commit the buffer never reaches the active copies
    buffer_hold_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        !commit |=> $stable(st.fr1) && $stable(st.fr2.auto_en) &&
                    $stable(st.fr2.master) && $stable(st.fr2.mask) &&
                    $stable(st.fr2.offset))
        else $error("active register changed without commit");

    // Reserved field always reads zero
    rsvd_zero_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        st.fr2.rsvd == mdcs_pkg::RSVD_VAL)
        else $error("reserved field is not zero");

    // Divided clock tracks the upper counter bit
    sync_clk_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        st.sync_clk == st.cnt[1])
        else $error("divided clock out of step with counter");

    // Pulse output quiet while automatic mode is off
    quiet_manual_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        !st.fr2.auto_en |-> !st.sync_out)
        else $error("sync pulse driven in manual mode");

    // A slave never drives pulses of its own
    slave_quiet_a: assert property (
        @(posedge clk iff clk_en) disable iff (!arst_n)
        slave_act |-> !st.sync_out)
        else $error("slave drove a sync pulse");

    // Freeze check looks at every edge, so it keeps its own clock;
    // a disabled edge must leave all state alone
    freeze_hold_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        !clk_en |=> $stable(st))
        else $error("state changed while clock enable was low");

endmodule

//--- include/mdcs_pkg.sv
/*
 * Constants, field layouts and state type for the multi-device sync
 * clock block. Assumes a single system clock domain; buffer and pin
 * signals are supplied by the serial port and pad logic around it.
 */
// Function
// - Auto sync enable bit turns on automatic mode; role bit picks master.
// - Master drives one-clock-wide sync pulses every fourth system clock.
// - Slave compares its divider to sampled pulses, stalls one cycle.
// - Automatic procedure aligns slaves within three divided clock periods.
// - Two-bit offset field covers 0 to 3 clocks delay; resets to 00.
// - Slave sets status flag when out of sync; cleared by a read.
// - Mask bit holds status low; sync keeps running regardless of flag.
// - Commit clearing manual software bit stalls divider exactly one cycle.
// - Each one-cycle stall shifts divided clock by a quarter period, 90 degrees.
// - Manual hardware mode stalls divider on each sync input rising edge.
// - Sync input idles high by pull-up; sync output unused when manual.
// - Divided sync clock comes from a divide-by-four counter, stall target.
// - Written values act only after the commit strobe moves them in.
package mdcs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Divider and comparison timing

    // Counter value in which the master emits its pulse
    localparam logic [1:0] CNT_PULSE  = 2'h0;
    // Counter step per enabled clock
    localparam logic [1:0] CNT_STEP   = 2'h1;
    // Counter reset value
    localparam logic [1:0] CNT_RST    = 2'h0;
    // Cycles from master counter zero to the second synchroniser stage
    localparam logic [1:0] SYNC_LAT   = 2'h2;
    // Synchroniser reset: pin idles high under its pull-up
    localparam logic [2:0] PIN_IDLE   = 3'h7;
    // Strobe synchroniser reset: no commit pending
    localparam logic [2:0] STB_IDLE   = 3'h0;
    // Delay line reset for the offset taps
    localparam logic [2:0] DLY_RST    = 3'h0;
    // Divided clock reset level
    localparam logic       SCLK_RST   = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Register field layouts

    // Function register one, manual sync controls
    typedef struct packed {
        logic       hw_sync;   // Stall on each sync input rising edge
        logic       sw_sync;   // Stall when a commit clears this bit
    } mdcs_fr1_t;

    // Function register two, automatic sync controls and status
    typedef struct packed {
        logic       auto_en;   // Automatic sync enable
        logic       master;    // 1 master, 0 slave
        logic       status;    // Out of sync, clear on read
        logic       mask;      // Holds status low
        logic [1:0] rsvd;      // Reads as zero
        logic [1:0] offset;    // Propagation delay compensation
    } mdcs_fr2_t;

    localparam mdcs_fr1_t FR1_RST = '{hw_sync: 1'b0, sw_sync: 1'b0};
    localparam mdcs_fr2_t FR2_RST = '{auto_en: 1'b0, master: 1'b0,
                                      status: 1'b0, mask: 1'b0,
                                      rsvd: 2'h0, offset: 2'h0};
    localparam logic [1:0] RSVD_VAL = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Complete module state

    typedef struct packed {
        logic [2:0] upd;       // Commit strobe sync stages and last level
        logic [2:0] sin;       // Sync input sync stages and last level
        logic [2:0] dly;       // Delayed copies of the sampled pulse
        logic [1:0] cnt;       // Divide-by-four counter
        logic       sync_clk;  // Divided clock output
        logic       sync_out;  // Master pulse output
        mdcs_fr1_t  fr1;       // Active function register one
        mdcs_fr2_t  fr2;       // Active function register two
    } mdcs_state_t;

endpackage

//--- testbench/mdcs_peer.sv
/*
 * Peer device acting as sync master: divide-by-four counter with a hold input,
 * one-clock pulse at count zero, pulse seen after a chosen pin delay.
 * Assumes the same clock and reset as the block under test.
 */
`timescale 1ns/1ns
module mdcs_peer (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       hold,
    input  wire logic [1:0] dly,
    output logic            pulse,
    output logic            div_clk
);
    logic [1:0] cnt;
    logic [2:0] sh;
    logic [3:0] tap;

    ////////////////////////////////////////////////////////////////////////
    // Counter with a stall input, so the bench can knock it out of phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 2'h0;
            sh  <= 3'h0;
        end else begin
            if (!hold) cnt <= cnt + 2'h1;
            sh <= {sh[1:0], tap[0]};
        end
    end

    // Pulse at count zero, delayed by whole clocks of wire delay
    assign tap     = {sh, cnt == 2'h0};
    assign pulse   = tap[dly];
    assign div_clk = cnt[1];
endmodule

//--- testbench/mdcs_top_tb.sv
/*
 * Self-checking bench for the sync clock block: reset, master pulses,
 * manual software and hardware stalls, slave alignment with offsets,
 * status flag and mask. Assumes the peer model beside it.
 */
`timescale 1ns/1ns
module mdcs_top_tb;
    logic                clk, arst_n, clk_en, io_update, reg_two_read;
    logic                pin_drv, use_peer, peer_hold, seen;
    logic                sync_out, sync_clk, peer_pulse, peer_clk;
    logic [1:0]          peer_dly;
    mdcs_pkg::mdcs_fr1_t b1, r1;
    mdcs_pkg::mdcs_fr2_t b2, r2;
    int                  fails, checks, cyc, p0, p1;

    // Pin idles high by its pull-up unless the peer drives it
    mdcs_top u_mdcs_top (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
        .function_reg_one_buf(b1), .function_reg_two_buf(b2),
        .io_update(io_update), .reg_two_read(reg_two_read),
        .sync_in(use_peer ? peer_pulse : pin_drv), .sync_out(sync_out),
        .sync_clk(sync_clk), .function_reg_one(r1),
        .function_reg_two(r2));
    mdcs_peer u_mdcs_peer (.clk(clk), .arst_n(arst_n), .hold(peer_hold),
        .dly(peer_dly), .pulse(peer_pulse), .div_clk(peer_clk));

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task final_report;
        if (fails == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic mdcs_pkg::mdcs_fr2_t f2(input logic a, m, k,
                                               input logic [1:0] o);
        f2 = mdcs_pkg::FR2_RST;
        f2.auto_en = a;
        f2.master  = m;
        f2.mask    = k;
        f2.offset  = o;
    endfunction
    // Commit to the block under test only; strobe held two clocks
    task commit(input mdcs_pkg::mdcs_fr1_t v1, mdcs_pkg::mdcs_fr2_t v2);
        b1 = v1;
        b2 = v2;
        io_update = 1'b1;
        step(2);
        io_update = 1'b0;
        step(3);
    endtask
    // Cycle phase of the next divided clock rise; no rise is fatal
    task get_ph(output int p);
        logic prev;
        p = -1;
        for (int i = 0; i < 8 && p < 0; i++) begin
            prev = sync_clk;
            step(1);
            if (sync_clk === 1'b1 && prev === 1'b0) p = cyc % 4;
        end
        if (p < 0) begin
            fails++;
            final_report();
        end
    endtask
    task stall_peer;
        reg_two_read = 1'b1;
        peer_hold = 1'b1;
        step(1);
        reg_two_read = 1'b0;
        peer_hold = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_master;
        b2 = f2(1'b1, 1'b1, 1'b0, 2'h0);
        // Status and reserved bits in the buffer must be ignored
        b2.status = 1'b1;
        b2.rsvd   = 2'h3;
        step(6);
        chk("fr2 before commit", 8'h00, r2);
        commit(mdcs_pkg::FR1_RST, b2);
        chk("fr2 master", 8'hC0, r2);
        for (int i = 0; i < 8 && sync_out !== 1'b1; i++) step(1);
        if (sync_out !== 1'b1) begin
            fails++;
            final_report();
        end
        for (int i = 0; i < 8; i++) begin
            chk("sync_out", {7'h00, i % 4 == 0}, sync_out);
            step(1);
        end
    endtask
    task t_manual;
        commit(2'h1, mdcs_pkg::FR2_RST);
        get_ph(p0);
        commit(2'h0, mdcs_pkg::FR2_RST);
        get_ph(p1);
        chk("sw stall phase", 8'((p0 + 1) % 4), 8'(p1));
        commit(2'h2, mdcs_pkg::FR2_RST);
        chk("fr1 hw", 8'h02, r1);
        get_ph(p0);
        pin_drv = 1'b0;
        step(2);
        pin_drv = 1'b1;
        step(4);
        get_ph(p1);
        chk("hw stall phase", 8'((p0 + 1) % 4), 8'(p1));
        chk("sync_out manual", 8'h00, sync_out);
    endtask
    // Clock enable low for three edges moves the phase by three
    task t_freeze;
        get_ph(p0);
        clk_en = 1'b0;
        step(3);
        chk("frozen sync_clk", 8'h01, sync_clk);
        clk_en = 1'b1;
        get_ph(p1);
        chk("freeze phase", 8'((p0 + 3) % 4), 8'(p1));
    endtask
    // Host repeats software stalls until in step with the peer
    task t_repeat;
        logic same;
        same = 1'b0;
        for (int n = 0; n < 5 && !same; n++) begin
            same = 1'b1;
            for (int i = 0; i < 4; i++) begin
                same &= (sync_clk === peer_clk);
                step(1);
            end
            if (!same) begin
                commit(2'h1, mdcs_pkg::FR2_RST);
                commit(2'h0, mdcs_pkg::FR2_RST);
            end
        end
        if (!same) begin
            fails++;
            final_report();
        end
        for (int i = 0; i < 8; i++) begin
            chk("manual aligned", {7'h00, peer_clk}, sync_clk);
            step(1);
        end
    endtask
    task t_slave(input logic [1:0] d, input logic k);
        peer_dly = d;
        commit(2'h0, f2(1'b1, 1'b0, k, d));
        step(16);
        stall_peer();
        seen = 1'b0;
        for (int i = 0; i < 16; i++) begin
            step(1);
            seen |= r2.status;
        end
        chk("status", {7'h00, ~k}, seen);
        for (int i = 0; i < 8; i++) begin
            chk("aligned", {7'h00, peer_clk}, sync_clk);
            step(1);
        end
        reg_two_read = 1'b1;
        step(1);
        reg_two_read = 1'b0;
        chk("status read", 8'h00, r2.status);
    endtask

    initial begin
        {arst_n, io_update, reg_two_read, use_peer, peer_hold} = 5'h00;
        {b1, b2, peer_dly, cyc, fails, checks} = '0;
        pin_drv = 1'b1;
        clk_en  = 1'b1;
        step(6);
        arst_n = 1'b1;
        step(1);
        chk("fr1 reset", 8'h00, r1);
        chk("fr2 reset", 8'h00, r2);
        t_master();
        t_manual();
        t_freeze();
        t_repeat();
        use_peer = 1'b1;
        for (int d = 0; d < 4; d++) t_slave(2'(d), 1'b0);
        t_slave(2'h0, 1'b1);
        final_report();
    end
endmodule
